// ===== hdl/mod_select_pkg.sv
// Shared constants and types for the modulation selection control block
`default_nettype none
package mod_select_pkg;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_CHB_FREQ = 8'h04;
  localparam logic [7:0] ADDR_KEYS = 8'h08;
  localparam logic [7:0] ADDR_SELECT = 8'h0C;
  localparam logic [7:0] ADDR_SETTING = 8'h10;
  localparam logic [7:0] ADDR_AMPL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // CONFIG fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_SUMMED_BIT = 2;

  // KEYS fields, each bit written as one is one key press
  localparam int KEY_A_AM_BIT = 0;
  localparam int KEY_A_PM_BIT = 1;
  localparam int KEY_B_AM_BIT = 2;
  localparam int KEY_B_PM_BIT = 3;
  localparam int KEY_PRESET_BIT = 4;
  localparam int KEY_SHOW_SETTING_BIT = 5;
  localparam int KEY_SHOW_OTHER_BIT = 6;
  localparam int KEY_PCT_UNIT_BIT = 7;
  localparam int KEY_DEG_UNIT_BIT = 8;

  // SETTING fields
  localparam int SET_VALUE_LSB = 0;
  localparam int SET_DEG_BIT = 16;

  // STATUS fields
  localparam int STAT_SET_REFUSED_BIT = 0;
  localparam int STAT_AMPL_REFUSED_BIT = 1;
  localparam int STAT_KEY_REFUSED_BIT = 2;
  localparam int STAT_SHOW_SETTING_BIT = 3;

  // Channel B frequency ceilings for internal modulation, in Hz
  localparam logic [31:0] INTERNAL_AMPLITUDE_MOD_SEL_MAX_FREQ_HZ = 32'h0001_86A0;
  localparam logic [31:0] INTERNAL_PHASE_MOD_SEL_MAX_FREQ_HZ = 32'h0000_1388;

  // Shared setting: tenths of a percent or hundredths of a degree
  localparam logic [15:0] SET_PCT_MAX = 16'h03E8;
  localparam logic [15:0] SET_DEG_MAX = 16'h8CA0;
  localparam logic [15:0] DEG_PER_PCT = 16'h0024;
  localparam logic [15:0] SET_RESET_VALUE = 16'h0000;

  localparam logic [31:0] APB_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_TWO_CHANNEL = 2'b00,
    MODE_TWO_PHASE = 2'b01,
    MODE_TWO_TONE = 2'b10,
    MODE_PULSE = 2'b11
  } op_mode_e;

  // Indicator flags; SELECT reads them in this order, first field highest
  typedef struct packed {
    logic a_internal_amplitude_mod_sel;
    logic a_external_amplitude_mod_sel;
    logic a_internal_phase_mod_sel;
    logic a_external_phase_mod_sel;
    logic dual_channel_locked_phase_mod_sel;
    logic b_external_amplitude_mod_sel;
    logic b_external_phase_mod_sel;
  } sel_flags_s;

  localparam sel_flags_s SEL_NONE = '0;

endpackage
`default_nettype wire

// ===== hdl/mod_setting_unit.sv
// Shared modulation depth/deviation setting with range check and unit conversion
`default_nettype none
module mod_setting_unit
  import mod_select_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Entry
  input wire logic write_i,
  input wire logic [15:0] write_value_i,
  input wire logic write_deg_i,
  input wire logic pct_key_i,
  input wire logic deg_key_i,
  // Setting
  output logic [15:0] value_o,
  output logic is_deg_o,
  output logic refused_o
);

  typedef struct packed {
    logic [15:0] value;
    logic is_deg;
    logic refused;
  } setting_s;

  setting_s st;
  setting_s next_st;

  always_comb
  begin
    next_st = st;
    if (write_i)
    begin
      // One stored value serves both modulation types
      if (write_deg_i ? (write_value_i > SET_DEG_MAX) : (write_value_i > SET_PCT_MAX))
      begin
        next_st.refused = 1'b1;
      end
      else
      begin
        next_st.refused = 1'b0;
        next_st.value = write_value_i;
        next_st.is_deg = write_deg_i;
      end
    end
    else if (pct_key_i && st.is_deg)
    begin
      // Truncates: some degree values lose their last hundredths
      next_st.value = st.value / DEG_PER_PCT;
      next_st.is_deg = 1'b0;
    end
    else if (deg_key_i && !st.is_deg)
    begin
      next_st.value = st.value * DEG_PER_PCT;
      next_st.is_deg = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st <= '{value: SET_RESET_VALUE, is_deg: 1'b0, refused: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign value_o = st.value;
  assign is_deg_o = st.is_deg;
  assign refused_o = st.refused;

endmodule
`default_nettype wire

// ===== hdl/modulation_select_control.sv
// Modulation selection control: key stepping, gating, routing and APB registers
//
// Design decisions made here: the address map and the APB register port.
`default_nettype none
// Behaviour
// - Each key press steps its indicator to the next permitted selection.
// - Choices depend on mode; internal only in two-channel mode, else synchronous PM.
// - Mode change, preset, or stepping all lit selections off clears modulation.
// - Internal modulation uses channel B as source; only channel A output stays.
// - Internal AM needs two-channel mode, no summed output, channel B below 100 kHz.
// - Internal PM needs two-channel mode, no summed output, channel B below 5 kHz.
// - Any internal modulation forces channel B high-voltage option off.
// - With AM active, channel A amplitude entries limited to half range.
// - Depth accepted from 0 to 100 percent in 0.1 percent steps.
// - Deviation accepted from 0 to 360 degrees in 0.01 degree steps.
// - One modulation setting serves both AM and PM.
// - Percent unit key converts a degree setting to percent.
// - Depth/deviation indicator lit while the setting is displayed.
// - Synchronous PM holds channel B phase fixed to channel A.
// - Non two-channel modes: synchronous PM drives both channels, B may add external PM.
// - Two-channel mode: external PM of A and B enabled independently.
// - External AM per channel routes that channel's input to its modulator.
module modulation_select_control
  import mod_select_pkg::*;
#(
  parameter int AMPL_W = 16,
  parameter logic [15:0] AMPL_MAX = 16'h03E8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Indicators
  output logic a_internal_amplitude_mod_sel_o,
  output logic a_external_amplitude_mod_sel_o,
  output logic a_internal_phase_mod_sel_o,
  output logic a_external_phase_mod_sel_o,
  output logic dual_channel_locked_phase_mod_sel_o,
  output logic b_external_amplitude_mod_sel_o,
  output logic b_external_phase_mod_sel_o,
  output logic mod_depth_deviation_entry_lit_o,
  // Synthesis and output path enables
  output logic chb_output_en_o,
  output logic chb_high_voltage_disable_o,
  output logic a_mod_from_chb_o,
  output logic a_am_input_en_o,
  output logic b_am_input_en_o,
  output logic a_pm_input_en_o,
  output logic b_pm_input_en_o,
  output logic b_pm_from_a_input_o,
  output logic b_phase_locked_to_a_o,
  // Settings
  output logic [15:0] mod_setting_o,
  output logic mod_setting_deg_o,
  output logic [AMPL_W-1:0] output_level_entry_o
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    op_mode_e mode;
    logic summed_output_operation;
    logic [31:0] chb_freq;
    sel_flags_s sel;
    logic show_setting;
    logic [AMPL_W-1:0] ampl;
    logic ampl_refused;
    logic key_refused;
    logic chb_out_en;
    logic chb_hv_dis;
    logic a_am_en;
    logic b_am_en;
    logic a_pm_en;
    logic b_pm_en;
    logic b_pm_from_a;
  } ctrl_s;

  ctrl_s st;
  ctrl_s next_st;

  logic rst_meta;
  logic rst_sync_n;

  logic setup_phase;
  logic wr_access;
  logic set_write;
  logic pct_key;
  logic deg_key;
  logic [15:0] setting_value;
  logic setting_deg;
  logic setting_refused;
  logic [31:0] read_word;
  logic addr_mapped;
  logic internal_amplitude_mod_sel_ok;
  logic internal_phase_mod_sel_ok;
  logic any_internal;
  logic a_am_active;
  logic [AMPL_W-1:0] ampl_limit;

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Internal source allowed only in two-channel mode, unsummed, below a channel B ceiling
  function automatic logic internal_ok(input op_mode_e mode, input logic summed,
                                       input logic [31:0] freq, input logic [31:0] ceiling,
                                       input logic other_internal);
    internal_ok = (mode == MODE_TWO_CHANNEL) && !summed && (freq < ceiling) && !other_internal;
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    unique case (addr)
      ADDR_CONFIG, ADDR_CHB_FREQ, ADDR_KEYS, ADDR_SELECT,
      ADDR_SETTING, ADDR_AMPL, ADDR_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  assign setup_phase = psel_i && !penable_i;
  assign wr_access = psel_i && penable_i && st.pready && pwrite_i && !st.pslverr;
  assign addr_mapped = is_mapped(paddr_i);
  assign set_write = wr_access && (paddr_i == ADDR_SETTING);
  assign pct_key = wr_access && (paddr_i == ADDR_KEYS) && pwdata_i[KEY_PCT_UNIT_BIT];
  assign deg_key = wr_access && (paddr_i == ADDR_KEYS) && pwdata_i[KEY_DEG_UNIT_BIT];

  assign internal_amplitude_mod_sel_ok = internal_ok(st.mode, st.summed_output_operation, st.chb_freq,
                                 INTERNAL_AMPLITUDE_MOD_SEL_MAX_FREQ_HZ, st.sel.a_internal_phase_mod_sel);
  assign internal_phase_mod_sel_ok = internal_ok(st.mode, st.summed_output_operation, st.chb_freq,
                                 INTERNAL_PHASE_MOD_SEL_MAX_FREQ_HZ, st.sel.a_internal_amplitude_mod_sel);
  assign ampl_limit = AMPL_W'(AMPL_MAX);

  mod_setting_unit setting_unit (
    .clk_i(clk_i),
    .reset_n_i(rst_sync_n),
    .write_i(set_write),
    .write_value_i(pwdata_i[SET_VALUE_LSB +: 16]),
    .write_deg_i(pwdata_i[SET_DEG_BIT]),
    .pct_key_i(pct_key),
    .deg_key_i(deg_key),
    .value_o(setting_value),
    .is_deg_o(setting_deg),
    .refused_o(setting_refused)
  );

  always_comb
  begin
    read_word = APB_ZERO;
    unique case (paddr_i)
      ADDR_CONFIG:
      begin
        read_word[CFG_MODE_LSB +: 2] = st.mode;
        read_word[CFG_SUMMED_BIT] = st.summed_output_operation;
      end
      ADDR_CHB_FREQ: read_word = st.chb_freq;
      ADDR_SELECT: read_word[$bits(sel_flags_s)-1:0] = st.sel;
      ADDR_SETTING:
      begin
        read_word[SET_VALUE_LSB +: 16] = setting_value;
        read_word[SET_DEG_BIT] = setting_deg;
      end
      ADDR_AMPL: read_word[AMPL_W-1:0] = st.ampl;
      ADDR_STATUS:
      begin
        read_word[STAT_SET_REFUSED_BIT] = setting_refused;
        read_word[STAT_AMPL_REFUSED_BIT] = st.ampl_refused;
        read_word[STAT_KEY_REFUSED_BIT] = st.key_refused;
        read_word[STAT_SHOW_SETTING_BIT] = st.show_setting;
      end
      default: read_word = APB_ZERO;
    endcase
  end

  always_comb
  begin
    next_st = st;
    any_internal = 1'b0;
    a_am_active = 1'b0;
    // No wait state: the answer is prepared during setup and shown in the first access cycle
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    if (setup_phase)
    begin
      next_st.pready = 1'b1;
      next_st.pslverr = !addr_mapped;
      next_st.prdata = (pwrite_i || !addr_mapped) ? APB_ZERO : read_word;
    end

    if (wr_access)
    begin
      unique case (paddr_i)
        ADDR_CONFIG:
        begin
          next_st.mode = op_mode_e'(pwdata_i[CFG_MODE_LSB +: 2]);
          next_st.summed_output_operation = pwdata_i[CFG_SUMMED_BIT];
          if (op_mode_e'(pwdata_i[CFG_MODE_LSB +: 2]) != st.mode)
          begin
            next_st.sel = SEL_NONE;
          end
        end
        ADDR_CHB_FREQ: next_st.chb_freq = pwdata_i;
        ADDR_KEYS:
        begin
          next_st.key_refused = 1'b0;
          if (pwdata_i[KEY_A_AM_BIT])
          begin
            // Off, internal when permitted, external, off
            if (st.sel.a_internal_amplitude_mod_sel)
            begin
              next_st.sel.a_internal_amplitude_mod_sel = 1'b0;
              next_st.sel.a_external_amplitude_mod_sel = 1'b1;
            end
            else if (st.sel.a_external_amplitude_mod_sel)
            begin
              next_st.sel.a_external_amplitude_mod_sel = 1'b0;
            end
            else if (internal_amplitude_mod_sel_ok)
            begin
              next_st.sel.a_internal_amplitude_mod_sel = 1'b1;
            end
            else
            begin
              next_st.key_refused = (st.mode == MODE_TWO_CHANNEL);
              next_st.sel.a_external_amplitude_mod_sel = 1'b1;
            end
          end
          if (pwdata_i[KEY_A_PM_BIT])
          begin
            if (st.mode != MODE_TWO_CHANNEL)
            begin
              // Only the synchronous choice exists outside two-channel mode
              next_st.sel.dual_channel_locked_phase_mod_sel =
                !st.sel.dual_channel_locked_phase_mod_sel;
            end
            else if (st.sel.a_internal_phase_mod_sel)
            begin
              next_st.sel.a_internal_phase_mod_sel = 1'b0;
              next_st.sel.a_external_phase_mod_sel = 1'b1;
            end
            else if (st.sel.a_external_phase_mod_sel)
            begin
              next_st.sel.a_external_phase_mod_sel = 1'b0;
            end
            else if (internal_phase_mod_sel_ok)
            begin
              next_st.sel.a_internal_phase_mod_sel = 1'b1;
            end
            else
            begin
              next_st.key_refused = 1'b1;
              next_st.sel.a_external_phase_mod_sel = 1'b1;
            end
          end
          if (pwdata_i[KEY_B_AM_BIT])
          begin
            next_st.sel.b_external_amplitude_mod_sel = !st.sel.b_external_amplitude_mod_sel;
          end
          if (pwdata_i[KEY_B_PM_BIT])
          begin
            next_st.sel.b_external_phase_mod_sel = !st.sel.b_external_phase_mod_sel;
          end
          if (pwdata_i[KEY_PRESET_BIT])
          begin
            next_st.sel = SEL_NONE;
            next_st.show_setting = 1'b0;
          end
          if (pwdata_i[KEY_SHOW_SETTING_BIT])
          begin
            next_st.show_setting = 1'b1;
          end
          else if (pwdata_i[KEY_SHOW_OTHER_BIT])
          begin
            next_st.show_setting = 1'b0;
          end
        end
        ADDR_SETTING: next_st.show_setting = 1'b1;
        ADDR_AMPL:
        begin
          // Half range while channel A is amplitude modulated
          if ((st.sel.a_internal_amplitude_mod_sel || st.sel.a_external_amplitude_mod_sel) ?
              (pwdata_i[AMPL_W-1:0] > (ampl_limit >> 1)) :
              (pwdata_i[AMPL_W-1:0] > ampl_limit))
          begin
            next_st.ampl_refused = 1'b1;
          end
          else
          begin
            next_st.ampl_refused = 1'b0;
            next_st.ampl = pwdata_i[AMPL_W-1:0];
          end
        end
        default: next_st.ampl_refused = st.ampl_refused;
      endcase
    end

    // Path controls follow the selections that take effect at the same edge
    any_internal = next_st.sel.a_internal_amplitude_mod_sel ||
                   next_st.sel.a_internal_phase_mod_sel;
    a_am_active = next_st.sel.a_external_amplitude_mod_sel;
    next_st.chb_out_en = !any_internal;
    next_st.chb_hv_dis = any_internal;
    next_st.a_am_en = a_am_active;
    next_st.b_am_en = next_st.sel.b_external_amplitude_mod_sel;
    next_st.a_pm_en = next_st.sel.a_external_phase_mod_sel ||
                      next_st.sel.dual_channel_locked_phase_mod_sel;
    next_st.b_pm_en = next_st.sel.b_external_phase_mod_sel;
    next_st.b_pm_from_a = next_st.sel.dual_channel_locked_phase_mod_sel;
  end

  always_ff @(posedge clk_i or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st <= '0;
      st.chb_out_en <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign a_internal_amplitude_mod_sel_o = st.sel.a_internal_amplitude_mod_sel;
  assign a_external_amplitude_mod_sel_o = st.sel.a_external_amplitude_mod_sel;
  assign a_internal_phase_mod_sel_o = st.sel.a_internal_phase_mod_sel;
  assign a_external_phase_mod_sel_o = st.sel.a_external_phase_mod_sel;
  assign dual_channel_locked_phase_mod_sel_o = st.sel.dual_channel_locked_phase_mod_sel;
  assign b_external_amplitude_mod_sel_o = st.sel.b_external_amplitude_mod_sel;
  assign b_external_phase_mod_sel_o = st.sel.b_external_phase_mod_sel;
  assign mod_depth_deviation_entry_lit_o = st.show_setting;
  assign chb_output_en_o = st.chb_out_en;
  assign chb_high_voltage_disable_o = st.chb_hv_dis;
  assign a_mod_from_chb_o = st.chb_hv_dis;
  assign a_am_input_en_o = st.a_am_en;
  assign b_am_input_en_o = st.b_am_en;
  assign a_pm_input_en_o = st.a_pm_en;
  assign b_pm_input_en_o = st.b_pm_en;
  assign b_pm_from_a_input_o = st.b_pm_from_a;
  assign b_phase_locked_to_a_o = st.b_pm_from_a;
  assign mod_setting_o = setting_value;
  assign mod_setting_deg_o = setting_deg;
  assign output_level_entry_o = st.ampl;

endmodule
`default_nettype wire

// ===== tb/mod_select_properties.sv
// Concurrent checks on the modulation selection control ports
`default_nettype none
module mod_select_properties
  import mod_select_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // Indicators
  input wire logic a_internal_amplitude_mod_sel_o,
  input wire logic a_external_amplitude_mod_sel_o,
  input wire logic a_internal_phase_mod_sel_o,
  input wire logic a_external_phase_mod_sel_o,
  input wire logic dual_channel_locked_phase_mod_sel_o,
  input wire logic b_external_amplitude_mod_sel_o,
  input wire logic b_external_phase_mod_sel_o,
  input wire logic mod_depth_deviation_entry_lit_o,
  // Path enables and setting
  input wire logic chb_output_en_o,
  input wire logic chb_high_voltage_disable_o,
  input wire logic a_mod_from_chb_o,
  input wire logic a_am_input_en_o,
  input wire logic b_am_input_en_o,
  input wire logic a_pm_input_en_o,
  input wire logic b_pm_input_en_o,
  input wire logic b_pm_from_a_input_o,
  input wire logic b_phase_locked_to_a_o,
  input wire logic [15:0] mod_setting_o,
  input wire logic mod_setting_deg_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic acc;
  logic intsel;
  logic sync;
  logic [6:0] flags;
  assign acc = psel_i && penable_i && pready_o && pwrite_i;
  assign intsel = a_internal_amplitude_mod_sel_o || a_internal_phase_mod_sel_o;
  assign sync = dual_channel_locked_phase_mod_sel_o;
  assign flags = {a_internal_amplitude_mod_sel_o, a_external_amplitude_mod_sel_o,
    a_internal_phase_mod_sel_o, a_external_phase_mod_sel_o, sync,
    b_external_amplitude_mod_sel_o, b_external_phase_mod_sel_o};
  a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("bus answer is not a single cycle");
  a_chb_off_int: assert property (chb_output_en_o == !intsel)
    else $error("channel B output enable wrong");
  a_src_from_chb: assert property (a_mod_from_chb_o == intsel)
    else $error("channel A source select wrong");
  a_hv_forced_off: assert property (chb_high_voltage_disable_o == intsel)
    else $error("high voltage option not forced off");
  a_am_routing: assert property ({a_am_input_en_o, b_am_input_en_o} == {flags[5], flags[1]})
    else $error("external amplitude routing wrong");
  a_pm_routing: assert property (a_pm_input_en_o == (flags[3] || sync)
    && b_pm_input_en_o == flags[0])
    else $error("external phase routing wrong");
  a_sync_lock: assert property (b_phase_locked_to_a_o == sync && b_pm_from_a_input_o == sync)
    else $error("synchronous lock outputs wrong");
  a_flags_on_access: assert property (!$stable(flags) |-> $past(acc))
    else $error("selection changed without a bus write");
  a_internal_amplitude_mod_sel_by_key: assert property ($rose(a_internal_amplitude_mod_sel_o)
    |-> $past(acc && paddr_i == ADDR_KEYS && pwdata_i[KEY_A_AM_BIT]))
    else $error("internal amplitude selected without its key");
  a_preset_clear: assert property (acc && paddr_i == ADDR_KEYS && pwdata_i[KEY_PRESET_BIT]
    |=> flags == 7'h00 && !mod_depth_deviation_entry_lit_o)
    else $error("preset left a selection lit");
  a_setting_range: assert property (mod_setting_o <= (mod_setting_deg_o ? SET_DEG_MAX
    : SET_PCT_MAX))
    else $error("setting out of range");
  a_setting_lights: assert property (acc && paddr_i == ADDR_SETTING
    && !pwdata_i[SET_DEG_BIT] && pwdata_i[15:0] <= SET_PCT_MAX
    |=> mod_depth_deviation_entry_lit_o && mod_setting_o == $past(pwdata_i[15:0]))
    else $error("accepted setting not shown");
  c_internal_amplitude_mod_sel: cover property (a_internal_amplitude_mod_sel_o);
  c_internal_phase_mod_sel: cover property (a_internal_phase_mod_sel_o);
  c_sync: cover property (sync && b_external_phase_mod_sel_o);
endmodule
`default_nettype wire

// ===== tb/apb_key_source.sv
// Bus master standing in for the key scanner and command parser
`default_nettype none
module apb_key_source
  import mod_select_pkg::*;
(
  // Clock and request from the bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] data_i,
  // Bus
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  // Result
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {psel_o, penable_o, pwrite_o, done_o, err_o} = 5'h00;
    paddr_o = 8'h00;
    pwdata_o = APB_ZERO;
    rdata_o = APB_ZERO;
  end
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (psel_o && penable_o && pready_i === 1'b1)
    begin
      // Released lines show the inverse so stale values never pass for valid
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
      done_o <= 1'b1;
      rdata_o <= prdata_i;
      err_o <= pslverr_i;
    end
    else if (psel_o)
      penable_o <= 1'b1;
    else if (go_i && !done_o)
    begin
      psel_o <= 1'b1;
      pwrite_o <= wr_i;
      paddr_o <= addr_i;
      pwdata_o <= data_i;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the modulation selection control block
`default_nettype none
module tb
  import mod_select_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, done, rd_err;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_data;
  logic a_internal_amplitude_mod_sel_o, a_external_amplitude_mod_sel_o;
  logic a_internal_phase_mod_sel_o, a_external_phase_mod_sel_o;
  logic dual_channel_locked_phase_mod_sel_o, b_external_amplitude_mod_sel_o;
  logic b_external_phase_mod_sel_o, mod_depth_deviation_entry_lit_o;
  logic chb_output_en_o, chb_high_voltage_disable_o, a_mod_from_chb_o;
  logic a_am_input_en_o, b_am_input_en_o, a_pm_input_en_o, b_pm_input_en_o;
  logic b_pm_from_a_input_o, b_phase_locked_to_a_o, mod_setting_deg_o;
  logic [15:0] mod_setting_o, output_level_entry_o;
  logic go = 1'b0, rw = 1'b0;
  logic [7:0] ad = 8'h00;
  logic [31:0] wd = APB_ZERO;
  int err_total = 0, total_checks = 0;
  always #50 clk_i = ~clk_i;
  modulation_select_control i_dut (.*);
  apb_key_source i_src (.clk_i(clk_i), .go_i(go), .wr_i(rw), .addr_i(ad), .data_i(wd),
    .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
    .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o),
    .done_o(done), .rdata_o(rd_data), .err_o(rd_err));
  function automatic logic [6:0] am_step(input logic [31:0] f);
    return (f < INTERNAL_AMPLITUDE_MOD_SEL_MAX_FREQ_HZ) ? 7'h40 : 7'h20;
  endfunction
  function automatic logic [6:0] pm_step(input logic [31:0] f);
    return (f < INTERNAL_PHASE_MOD_SEL_MAX_FREQ_HZ) ? 7'h10 : 7'h08;
  endfunction
  function automatic logic [16:0] accept(input logic [16:0] nv, input logic [16:0] old);
    return (nv[15:0] <= (nv[16] ? SET_DEG_MAX : SET_PCT_MAX)) ? nv : old;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
    total_checks++;
    if (got !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    go <= 1'b1;
    rw <= w;
    ad <= a;
    wd <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (done !== 1'b1 && n < 50);
    go <= 1'b0;
    if (n >= 50)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic key(input int b, input logic [6:0] e);
    bus(1'b1, ADDR_KEYS, 32'h1 << b);
    bus(1'b0, ADDR_SELECT, APB_ZERO);
    chk("select", 32'(e), rd_data);
  endtask
  initial
  begin
    logic [31:0] f;
    logic [16:0] nv, cur;
    logic [16:0] tbl [5] = '{17'h003E8, 17'h003E9, 17'h18CA0, 17'h18CA1, 17'h00000};
    void'($urandom(80241));
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("chb_en", 32'h1, 32'(chb_output_en_o));
    key(KEY_SHOW_OTHER_BIT, 7'h00);
    bus(1'b0, 8'h1C, APB_ZERO);
    chk("slverr", 32'h1, 32'(rd_err));
    bus(1'b1, ADDR_CHB_FREQ, 32'h0001_869F);
    key(KEY_A_AM_BIT, 7'h40);
    chk("chb_en", 32'h0, 32'(chb_output_en_o));
    chk("hv_off", 32'h1, 32'(chb_high_voltage_disable_o));
    bus(1'b1, ADDR_AMPL, 32'h0000_01F5);
    chk("ampl", 32'h0, 32'(output_level_entry_o));
    bus(1'b1, ADDR_AMPL, 32'h0000_01F4);
    chk("ampl", 32'h1F4, 32'(output_level_entry_o));
    key(KEY_A_PM_BIT, 7'h48);
    key(KEY_A_AM_BIT, 7'h28);
    key(KEY_A_AM_BIT, 7'h08);
    key(KEY_A_PM_BIT, 7'h00);
    bus(1'b1, ADDR_AMPL, 32'h0000_03E8);
    chk("ampl", 32'h3E8, 32'(output_level_entry_o));
    bus(1'b1, ADDR_CHB_FREQ, 32'h0001_86A0);
    key(KEY_A_AM_BIT, 7'h20);
    key(KEY_A_AM_BIT, 7'h00);
    bus(1'b1, ADDR_CHB_FREQ, 32'h0000_1387);
    key(KEY_A_PM_BIT, 7'h10);
    key(KEY_A_PM_BIT, 7'h08);
    key(KEY_A_PM_BIT, 7'h00);
    bus(1'b1, ADDR_CONFIG, 32'h0000_0004);
    key(KEY_A_PM_BIT, 7'h08);
    key(KEY_A_PM_BIT, 7'h00);
    key(KEY_A_AM_BIT, 7'h20);
    key(KEY_A_AM_BIT, 7'h00);
    bus(1'b1, ADDR_CONFIG, APB_ZERO);
    key(KEY_B_AM_BIT, 7'h02);
    chk("b_am_en", 32'h1, 32'(b_am_input_en_o));
    key(KEY_B_PM_BIT, 7'h03);
    chk("pm_en", 32'h1, 32'({a_pm_input_en_o, b_pm_input_en_o}));
    for (int m = 1; m < 4; m++)
    begin
      bus(1'b1, ADDR_CONFIG, 32'(m));
      bus(1'b0, ADDR_SELECT, APB_ZERO);
      chk("mode_clear", 32'h0, rd_data);
      key(KEY_A_AM_BIT, 7'h20);
      key(KEY_A_PM_BIT, 7'h24);
      key(KEY_B_PM_BIT, 7'h25);
      chk("lock", 32'h7, 32'({a_pm_input_en_o, b_pm_input_en_o, b_phase_locked_to_a_o}));
    end
    key(KEY_PRESET_BIT, 7'h00);
    bus(1'b1, ADDR_CONFIG, APB_ZERO);
    // Random channel B frequencies straddle both internal ceilings
    repeat (8)
    begin
      f = $urandom_range(0, 200000);
      bus(1'b1, ADDR_CHB_FREQ, f);
      key(KEY_A_AM_BIT, am_step(f));
      key(KEY_PRESET_BIT, 7'h00);
      f = $urandom_range(0, 10000);
      bus(1'b1, ADDR_CHB_FREQ, f);
      key(KEY_A_PM_BIT, pm_step(f));
      key(KEY_PRESET_BIT, 7'h00);
    end
    cur = 17'h00000;
    for (int i = 0; i < 13; i++)
    begin
      nv = (i < 5) ? tbl[i] : {1'($urandom_range(0, 1)), 16'($urandom_range(0, 37000))};
      bus(1'b1, ADDR_SETTING, 32'(nv));
      cur = accept(nv, cur);
      chk("setting", 32'(cur), 32'({mod_setting_deg_o, mod_setting_o}));
      chk("lit", 32'h1, 32'(mod_depth_deviation_entry_lit_o));
      bus(1'b1, ADDR_KEYS, 32'h1 << (cur[16] ? KEY_PCT_UNIT_BIT : KEY_DEG_UNIT_BIT));
      cur = cur[16] ? {1'b0, cur[15:0] / DEG_PER_PCT} : {1'b1, cur[15:0] * DEG_PER_PCT};
      chk("unit", 32'(cur), 32'({mod_setting_deg_o, mod_setting_o}));
    end
    bus(1'b1, ADDR_KEYS, 32'h1 << KEY_SHOW_OTHER_BIT);
    chk("lit", 32'h0, 32'(mod_depth_deviation_entry_lit_o));
    conclude();
  end
endmodule
bind modulation_select_control mod_select_properties i_props (.*);
`default_nettype wire
